//--- rtl/pclu_top.sv
// Added by the designer: the address map and the AHB-Lite register port.
module pclu_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic core_step,
    input wire logic core_branch,
    input wire logic [pclu_pkg::PC_W-1:0] core_branch_target,
    input wire logic core_low_wr,
    input wire logic [pclu_pkg::LOW_W-1:0] core_low_wdata,
    input wire logic core_low_rd,
    output logic [pclu_pkg::LOW_W-1:0] core_low_rdata,
    output logic [pclu_pkg::PC_W-1:0] fetch_address
);

    logic wr_pulse;
    logic rd_pulse;
    logic [pclu_pkg::ADDR_W-1:0] reg_addr;
    logic [31:0] reg_rdata;
    logic [pclu_pkg::HIGH_W-1:0] high_latch;
    logic [pclu_pkg::UPPER_W-1:0] upper_latch;

    logic sw_low_wr;
    logic sw_low_rd;
    logic sw_high_wr;
    logic sw_upper_wr;
    logic sw_ctrl_wr;
    logic low_wr_any;
    logic [pclu_pkg::LOW_W-1:0] low_wdata;

    logic [pclu_pkg::PC_W-1:0] pc_q;
    logic [pclu_pkg::PC_W-1:0] pc_d;
    pclu_pkg::pclu_src_type src_q;
    pclu_pkg::pclu_src_type src_d;
    logic step_en_q;
    logic step_en_d;
    logic [pclu_pkg::LOW_W-1:0] low_rdata_q;
    logic [pclu_pkg::LOW_W-1:0] low_rdata_d;

    pclu_ahb_slave u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hready(hready),
        .reg_rdata(reg_rdata),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .wr_pulse(wr_pulse),
        .rd_pulse(rd_pulse),
        .reg_addr(reg_addr)
    );

    // Register decode
    always_comb begin
        sw_low_wr = wr_pulse && (reg_addr == pclu_pkg::OFF_LOW);
        sw_low_rd = rd_pulse && (reg_addr == pclu_pkg::OFF_LOW);
        sw_high_wr = wr_pulse && (reg_addr == pclu_pkg::OFF_HIGH_LATCH);
        sw_upper_wr = wr_pulse && (reg_addr == pclu_pkg::OFF_UPPER_LATCH);
        sw_ctrl_wr = wr_pulse && (reg_addr == pclu_pkg::OFF_CONTROL);
        low_wr_any = core_low_wr || sw_low_wr;
        low_wdata = core_low_wr ? core_low_wdata : hwdata[pclu_pkg::LOW_W-1:0];
    end

    // Read mux; counter high and upper bytes have no register of their own
    always_comb begin
        reg_rdata = 32'h00000000;
        unique case (reg_addr)
            pclu_pkg::OFF_LOW: begin
                reg_rdata[pclu_pkg::LOW_W-1:0] = pc_q[pclu_pkg::LOW_W-1:0];
            end
            pclu_pkg::OFF_HIGH_LATCH: begin
                reg_rdata[pclu_pkg::HIGH_W-1:0] = high_latch;
            end
            pclu_pkg::OFF_UPPER_LATCH: begin
                reg_rdata[pclu_pkg::UPPER_W-1:0] = upper_latch;
            end
            pclu_pkg::OFF_CONTROL: begin
                reg_rdata[pclu_pkg::CTRL_STEP_EN_BIT] = step_en_q;
            end
            pclu_pkg::OFF_STATUS: begin
                reg_rdata[pclu_pkg::PC_W-1:0] = pc_q;
                reg_rdata[pclu_pkg::STAT_SRC_LSB +: 2] = src_q;
            end
            default: begin
                reg_rdata = 32'h00000000;
            end
        endcase
    end

    pclu_latches u_latches (
        .hclk(hclk),
        .hresetn(hresetn),
        .copy_en(core_low_rd || sw_low_rd),
        .pc_now(pc_q),
        .high_wr(sw_high_wr),
        .upper_wr(sw_upper_wr),
        .wdata(hwdata),
        .high_latch(high_latch),
        .upper_latch(upper_latch)
    );

    // Counter next value: branch, then low-byte write, then sequential step
    always_comb begin
        pc_d = pc_q;
        src_d = src_q;
        if (core_branch) begin
            pc_d = core_branch_target;
            src_d = pclu_pkg::SRC_BRANCH;
        end else if (low_wr_any) begin
            pc_d = {upper_latch, high_latch, low_wdata};
            src_d = pclu_pkg::SRC_LOW_WRITE;
        end else if (core_step && step_en_q) begin
            pc_d = pc_q + pclu_pkg::PC_STEP;
            src_d = pclu_pkg::SRC_STEP;
        end
        pc_d[0] = 1'b0;
    end

    always_comb begin
        step_en_d = step_en_q;
        if (sw_ctrl_wr) begin
            step_en_d = hwdata[pclu_pkg::CTRL_STEP_EN_BIT];
        end
        low_rdata_d = low_rdata_q;
        if (core_low_rd) begin
            low_rdata_d = pc_q[pclu_pkg::LOW_W-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_q <= pclu_pkg::PC_RESET;
            src_q <= pclu_pkg::SRC_RESET;
            step_en_q <= pclu_pkg::CTRL_STEP_EN_RESET;
            low_rdata_q <= 8'h00;
        end else begin
            pc_q <= pc_d;
            src_q <= src_d;
            step_en_q <= step_en_d;
            low_rdata_q <= low_rdata_d;
        end
    end

    assign fetch_address = pc_q;
    assign core_low_rdata = low_rdata_q;

endmodule // pclu_top

//--- rtl/pclu_pkg.sv
package pclu_pkg;

    localparam int PC_W = 21;
    localparam int HIGH_W = 8;
    localparam int UPPER_W = 5;
    localparam int LOW_W = 8;
    localparam int HIGH_LSB = 8;
    localparam int UPPER_LSB = 16;

    localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
    localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
    localparam logic [HIGH_W-1:0] HIGH_LATCH_RESET = 8'h00;
    localparam logic [UPPER_W-1:0] UPPER_LATCH_RESET = 5'h00;

    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_LOW = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_HIGH_LATCH = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_UPPER_LATCH = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;

    localparam int CTRL_STEP_EN_BIT = 0;
    localparam logic CTRL_STEP_EN_RESET = 1'b1;
    localparam int STAT_SRC_LSB = 24;

    typedef enum logic [1:0] {
        SRC_RESET,
        SRC_STEP,
        SRC_BRANCH,
        SRC_LOW_WRITE
    } pclu_src_type;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ_WAIT,
        BUS_READ_DONE
    } pclu_bus_state_type;

endpackage

//--- rtl/pclu_latches.sv
module pclu_latches (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic copy_en,
    input wire logic [pclu_pkg::PC_W-1:0] pc_now,
    input wire logic high_wr,
    input wire logic upper_wr,
    input wire logic [31:0] wdata,
    output logic [pclu_pkg::HIGH_W-1:0] high_latch,
    output logic [pclu_pkg::UPPER_W-1:0] upper_latch
);

    logic [pclu_pkg::HIGH_W-1:0] high_q;
    logic [pclu_pkg::HIGH_W-1:0] high_d;
    logic [pclu_pkg::UPPER_W-1:0] upper_q;
    logic [pclu_pkg::UPPER_W-1:0] upper_d;

    always_comb begin
        high_d = high_q;
        upper_d = upper_q;
        if (high_wr) begin
            high_d = wdata[pclu_pkg::HIGH_W-1:0];
        end
        if (upper_wr) begin
            upper_d = wdata[pclu_pkg::UPPER_W-1:0];
        end
        if (copy_en) begin
            // Copy of live counter bytes wins over a latch write
            high_d = pc_now[pclu_pkg::HIGH_LSB +: pclu_pkg::HIGH_W];
            upper_d = pc_now[pclu_pkg::UPPER_LSB +: pclu_pkg::UPPER_W];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_q <= pclu_pkg::HIGH_LATCH_RESET;
            upper_q <= pclu_pkg::UPPER_LATCH_RESET;
        end else begin
            high_q <= high_d;
            upper_q <= upper_d;
        end
    end

    assign high_latch = high_q;
    assign upper_latch = upper_q;

endmodule // pclu_latches

//--- rtl/pclu_ahb_slave.sv
module pclu_ahb_slave (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] reg_rdata,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic wr_pulse,
    output logic rd_pulse,
    output logic [pclu_pkg::ADDR_W-1:0] reg_addr
);

    pclu_pkg::pclu_bus_state_type state_q;
    pclu_pkg::pclu_bus_state_type state_d;
    logic [pclu_pkg::ADDR_W-1:0] addr_q;
    logic [pclu_pkg::ADDR_W-1:0] addr_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic ready_q;
    logic ready_d;
    logic accept;

    // Only whole-word single transfers are used; size is not decoded
    always_comb begin
        accept = hsel && hready && htrans[1] && (hsize == hsize);
        state_d = state_q;
        addr_d = addr_q;
        rdata_d = rdata_q;
        wr_pulse = 1'b0;
        rd_pulse = 1'b0;
        unique case (state_q)
            pclu_pkg::BUS_IDLE, pclu_pkg::BUS_READ_DONE, pclu_pkg::BUS_WRITE: begin
                wr_pulse = (state_q == pclu_pkg::BUS_WRITE);
                state_d = pclu_pkg::BUS_IDLE;
                if (accept) begin
                    addr_d = {haddr[pclu_pkg::ADDR_W-1:2], 2'h0};
                    state_d = hwrite ? pclu_pkg::BUS_WRITE : pclu_pkg::BUS_READ_WAIT;
                end
            end
            pclu_pkg::BUS_READ_WAIT: begin
                // One wait state so the read sees every earlier write
                rd_pulse = 1'b1;
                rdata_d = reg_rdata;
                state_d = pclu_pkg::BUS_READ_DONE;
            end
        endcase
        ready_d = (state_d != pclu_pkg::BUS_READ_WAIT);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= pclu_pkg::BUS_IDLE;
            addr_q <= 8'h00;
            rdata_q <= 32'h00000000;
            ready_q <= 1'b1;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
        end
    end

    assign reg_addr = addr_q;
    assign hreadyout = ready_q;
    assign hrdata = rdata_q;
    assign hresp = 1'b0;

endmodule // pclu_ahb_slave

//--- verif/pclu_checker_assertions.sv
module pclu_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic core_step,
    input wire logic core_branch,
    input wire logic [pclu_pkg::PC_W-1:0] core_branch_target,
    input wire logic core_low_wr,
    input wire logic [pclu_pkg::LOW_W-1:0] core_low_wdata,
    input wire logic core_low_rd,
    input wire logic [pclu_pkg::LOW_W-1:0] core_low_rdata,
    input wire logic [pclu_pkg::PC_W-1:0] fetch_address
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_step_adds_two: assert property (core_step && !core_branch && !core_low_wr && !hsel
        && !$past(hsel) |=> fetch_address == $past(fetch_address) + 21'h000002)
        else $error("step did not advance by two");
    a_bit_zero: assert property (fetch_address[0] == 1'b0)
        else $error("counter bit zero set");
    a_branch_load: assert property (core_branch |=>
        fetch_address == {$past(core_branch_target[20:1]), 1'b0}) else $error("branch not loaded");
    a_low_write: assert property (core_low_wr && !core_branch |=>
        fetch_address[7:0] == {$past(core_low_wdata[7:1]), 1'b0}) else $error("low write lost");
    a_read_capture: assert property (core_low_rd |=>
        core_low_rdata == $past(fetch_address[7:0])) else $error("low read wrong");
    a_idle_hold: assert property (!core_step && !core_branch && !core_low_wr && !hsel
        && !$past(hsel) |=> $stable(fetch_address)) else $error("counter moved while idle");
    a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=>
        !hreadyout ##1 hreadyout) else $error("read wait state wrong");
    a_write_nowait: assert property (hsel && hready && htrans[1] && hwrite |=>
        hreadyout) else $error("write stalled");
endmodule // pclu_checker

bind pclu_top pclu_checker pclu_checker_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .core_step(core_step), .core_branch(core_branch), .core_branch_target(core_branch_target),
    .core_low_wr(core_low_wr), .core_low_wdata(core_low_wdata), .core_low_rd(core_low_rd),
    .core_low_rdata(core_low_rdata), .fetch_address(fetch_address));

//--- verif/pclu_core_model.sv
module pclu_core_model (
    input wire logic hclk,
    output logic core_step,
    output logic core_branch,
    output logic [pclu_pkg::PC_W-1:0] core_branch_target,
    output logic core_low_wr,
    output logic [pclu_pkg::LOW_W-1:0] core_low_wdata,
    output logic core_low_rd
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {core_step, core_branch, core_low_wr, core_low_rd} = 4'h0;
        core_branch_target = 21'h000000;
        core_low_wdata = 8'h00;
    end
    // One instruction request held for one cycle
    task automatic issue(input logic [1:0] kind, input logic [20:0] v);
        @(posedge hclk);
        core_step <= kind == 2'h0;
        core_branch <= kind == 2'h1;
        core_low_wr <= kind == 2'h2;
        core_low_rd <= kind == 2'h3;
        core_branch_target <= v;
        core_low_wdata <= v[7:0];
        @(posedge hclk);
        {core_step, core_branch, core_low_wr, core_low_rd} <= 4'h0;
        core_branch_target <= ~v;
        core_low_wdata <= ~v[7:0];
        #1;
    endtask
endmodule // pclu_core_model

//--- verif/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic core_step, core_branch, core_low_wr, core_low_rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    logic [20:0] core_branch_target, fetch_address;
    logic [7:0] core_low_wdata, core_low_rdata;
    int failures = 0;
    int tests_run = 0;
    assign hready = hreadyout;
    pclu_top pclu_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .core_step(core_step),
        .core_branch(core_branch), .core_branch_target(core_branch_target),
        .core_low_wr(core_low_wr), .core_low_wdata(core_low_wdata), .core_low_rd(core_low_rd),
        .core_low_rdata(core_low_rdata), .fetch_address(fetch_address));
    pclu_core_model pclu_core_model_inst (.hclk(hclk), .core_step(core_step),
        .core_branch(core_branch), .core_branch_target(core_branch_target),
        .core_low_wr(core_low_wr), .core_low_wdata(core_low_wdata), .core_low_rd(core_low_rd));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h00000000, r);
        chk(r, e);
    endtask
    task automatic give_verdict;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    initial begin
        #50000;
        failures++;
        give_verdict();
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        chk(32'(fetch_address), 32'h00000000);
        rdc(pclu_pkg::OFF_HIGH_LATCH, 32'h00000000);
        rdc(pclu_pkg::OFF_UPPER_LATCH, 32'h00000000);
        rdc(pclu_pkg::OFF_CONTROL, 32'h00000001);
        repeat (3) pclu_core_model_inst.issue(2'h0, 21'h000000);
        chk(32'(fetch_address), 32'h00000006);
        pclu_core_model_inst.issue(2'h1, 21'h01ABCD);
        chk(32'(fetch_address), 32'h0001ABCC);
        rdc(pclu_pkg::OFF_HIGH_LATCH, 32'h00000000);
        pclu_core_model_inst.issue(2'h3, 21'h000000);
        chk(32'(core_low_rdata), 32'h000000CC);
        rdc(pclu_pkg::OFF_HIGH_LATCH, 32'h000000AB);
        rdc(pclu_pkg::OFF_UPPER_LATCH, 32'h00000001);
        wr(pclu_pkg::OFF_HIGH_LATCH, 32'h00000012);
        wr(pclu_pkg::OFF_UPPER_LATCH, 32'h00000003);
        pclu_core_model_inst.issue(2'h2, 21'h000057);
        chk(32'(fetch_address), 32'h00031256);
        wr(pclu_pkg::OFF_UPPER_LATCH, 32'h000000FF);
        wr(pclu_pkg::OFF_HIGH_LATCH, 32'h00000034);
        wr(pclu_pkg::OFF_LOW, 32'h00000081);
        chk(32'(fetch_address), 32'h001F3480);
        rdc(pclu_pkg::OFF_LOW, 32'h00000080);
        pclu_core_model_inst.issue(2'h1, 21'h0F0F02);
        rdc(pclu_pkg::OFF_LOW, 32'h00000002);
        rdc(pclu_pkg::OFF_HIGH_LATCH, 32'h0000000F);
        rdc(pclu_pkg::OFF_UPPER_LATCH, 32'h0000000F);
        rdc(8'h20, 32'h00000000);
        chk(32'(hresp), 32'h00000000);
        rdc(pclu_pkg::OFF_STATUS, 32'h020F0F02);
        give_verdict();
    end
endmodule // testbench
